/* File: rrs_pkg.sv */
// Constants, register map and carrier types for the four-instruction executor.
// Assumes a single 125 MHz clock domain and a 32-bit AXI4-Lite register bus.
package rrs_pkg;
	localparam int          ADDR_W       = 6;
	localparam int          DATA_W       = 8;
	// Register byte offsets
	localparam logic [5:0]  OFF_CMD      = 6'h00;
	localparam logic [5:0]  OFF_STATUS   = 6'h04;
	localparam logic [5:0]  OFF_WREG     = 6'h08;
	localparam logic [5:0]  OFF_PC       = 6'h0c;
	localparam logic [5:0]  OFF_STACK    = 6'h10;
	localparam logic [5:0]  OFF_FPTR     = 6'h14;
	localparam logic [5:0]  OFF_FDATA    = 6'h18;
	localparam logic [5:0]  OFF_WDOG     = 6'h1c;
	localparam logic [5:0]  OFF_WAKE     = 6'h20;
	// Command word fields
	localparam int          CMD_OP_LSB   = 0;
	localparam int          CMD_LIT_LSB  = 8;
	localparam int          CMD_FA_LSB   = 16;
	localparam int          CMD_DEST_BIT = 24;
	localparam int          FA_W         = 7;
	// Status word bits
	localparam int          ST_BUSY_BIT  = 0;
	localparam int          ST_SLEEP_BIT = 1;
	localparam int          ST_CARRY_BIT = 2;
	localparam int          ST_TO_BIT    = 3;
	localparam int          ST_PD_BIT    = 4;
	localparam int          ST_OSC_BIT   = 5;
	// Opcodes
	localparam logic [1:0]  OP_RET_LIT   = 2'h0;
	localparam logic [1:0]  OP_ROT_RIGHT = 2'h1;
	localparam logic [1:0]  OP_RET_SUB   = 2'h2;
	localparam logic [1:0]  OP_SLEEP     = 2'h3;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// Reset values
	localparam logic [7:0]  W_RESET      = 8'h00;
	localparam logic [2:0]  FLAGS_RESET  = 3'h6;

	typedef enum logic [2:0]
	{
		ST_RUN   = 3'b001,
		ST_RET2  = 3'b010,
		ST_SLEEP = 3'b100
	} rrs_state_t;

	typedef struct packed
	{
		logic carry;
		logic timeout_flag;
		logic power_down_flag;
	} rrs_flags_t;

	typedef struct packed
	{
		logic [1:0]      op;
		logic [7:0]      lit;
		logic [FA_W-1:0] faddr;
		logic            dest;
	} rrs_instr_t;
endpackage

/* File: rrs_exec.sv */
// Executor for literal return, rotate right via carry, subroutine return and sleep,
// with an AXI4-Lite register slave. Assumes one clock and synchronous active-low reset.
//
// Function
// - return_with_literal loads the accumulator with its 8-bit literal, reloads the PC from stack_top_entry, two cycles.
// - return_with_literal leaves every status flag unchanged.
// - rotate_right_via_carry shifts the file register toward bit 0, old carry into bit 7, bit 0 into carry.
// - rotate_right_via_carry takes a 7-bit file address; selector 0 writes the accumulator, 1 writes back the register.
// - subroutine return pops the stack into the PC in two cycles and changes no flag.
// - sleep clears power_down_flag and sets timeout_flag and leaves carry unchanged.
// - sleep clears the watchdog_counter to zero and clears its prescaler.
// - after sleep the core halts the oscillator and stops executing instructions.
`timescale 1ns/1ps
module rrs_exec
	import rrs_pkg::*;
#(
	parameter int PC_W        = 13,
	parameter int STACK_DEPTH = 8,
	parameter int FILE_DEPTH  = 128,
	parameter int WDT_W       = 8,
	parameter int PRESC_W     = 8
)
(
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	// AXI4-Lite write
	input  wire logic [rrs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// AXI4-Lite read
	input  wire logic [rrs_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Core state
	output logic                          osc_run,
	output logic                          sleep_active
);
	import rrs_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH);

	rrs_state_t              state_q;
	rrs_flags_t              flags_q;
	logic [DATA_W-1:0]       w_q;
	logic [PC_W-1:0]         pc_q;
	logic [PC_W-1:0]         ret_pc_q;
	logic [PC_W-1:0]         stack_q [STACK_DEPTH];
	logic [SP_W-1:0]         sp_q;
	logic [DATA_W-1:0]       file_q [FILE_DEPTH];
	logic [FA_W-1:0]         fptr_q;
	logic [WDT_W-1:0]        wdt_q;
	logic [PRESC_W-1:0]      presc_q;
	logic                    aw_full_q;
	logic                    w_full_q;
	logic [ADDR_W-1:0]       aw_addr_q;
	logic [31:0]             w_data_q;
	logic [3:0]              w_strb_q;
	logic                    bvalid_q;
	logic [1:0]              bresp_q;
	logic                    rvalid_q;
	logic [1:0]              rresp_q;
	logic [31:0]             rdata_q;
	logic                    wr_fire;
	logic [31:0]             wr_word;
	logic [31:0]             rd_mux;
	logic                    cmd_go;
	rrs_instr_t              instr;
	logic [PC_W-1:0]         top_entry;
	logic [DATA_W-1:0]       fval;
	logic [DATA_W-1:0]       rot_res;
	logic                    busy;

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		return a == OFF_CMD || a == OFF_STATUS || a == OFF_WREG || a == OFF_PC || a == OFF_STACK ||
			a == OFF_FPTR || a == OFF_FDATA || a == OFF_WDOG || a == OFF_WAKE;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// Write channel: address and data latch independently, the action waits for both
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready  = !w_full_q && !bvalid_q;
	assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;
	assign wr_word       = merge(32'h0000_0000, w_data_q, w_strb_q);
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= addr_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Read channel
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			OFF_STATUS:
			begin
				rd_mux[ST_BUSY_BIT]  = busy;
				rd_mux[ST_SLEEP_BIT] = sleep_active;
				rd_mux[ST_CARRY_BIT] = flags_q.carry;
				rd_mux[ST_TO_BIT]    = flags_q.timeout_flag;
				rd_mux[ST_PD_BIT]    = flags_q.power_down_flag;
				rd_mux[ST_OSC_BIT]   = osc_run;
			end
			OFF_WREG:  rd_mux[DATA_W-1:0] = w_q;
			OFF_PC:    rd_mux[PC_W-1:0]   = pc_q;
			OFF_STACK: rd_mux[PC_W-1:0]   = top_entry;
			OFF_FPTR:  rd_mux[FA_W-1:0]   = fptr_q;
			OFF_FDATA: rd_mux[DATA_W-1:0] = file_q[fptr_q];
			OFF_WDOG:  rd_mux[WDT_W-1:0]  = wdt_q;
			default:   rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= rd_mux;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// Instruction issue: a command written while busy or asleep is dropped
	assign instr        = '{op: wr_word[CMD_OP_LSB +: 2], lit: wr_word[CMD_LIT_LSB +: 8],
		faddr: wr_word[CMD_FA_LSB +: FA_W], dest: wr_word[CMD_DEST_BIT]};
	assign cmd_go       = wr_fire && aw_addr_q == OFF_CMD && state_q == ST_RUN;
	assign top_entry    = stack_q[sp_q - SP_W'(1)];
	assign fval         = file_q[instr.faddr];
	assign rot_res      = {flags_q.carry, fval[DATA_W-1:1]};
	assign busy         = state_q == ST_RET2;
	assign sleep_active = state_q == ST_SLEEP;
	assign osc_run      = !sleep_active;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			state_q <= ST_RUN;
		else
		begin
			unique case (state_q)
				ST_RUN:
					if (cmd_go && (instr.op == OP_RET_LIT || instr.op == OP_RET_SUB))
						state_q <= ST_RET2;
					else if (cmd_go && instr.op == OP_SLEEP)
						state_q <= ST_SLEEP;
				ST_RET2:
					state_q <= ST_RUN;
				// No hardware wake-up source here; a write with bit 0 set to OFF_WAKE releases sleep
				ST_SLEEP:
					if (wr_fire && aw_addr_q == OFF_WAKE && wr_word[0])
						state_q <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			w_q <= W_RESET;
		else if (cmd_go && instr.op == OP_RET_LIT)
			w_q <= instr.lit;
		else if (cmd_go && instr.op == OP_ROT_RIGHT && !instr.dest)
			w_q <= rot_res;
		else if (wr_fire && aw_addr_q == OFF_WREG)
			w_q <= wr_word[DATA_W-1:0];
	end

	// Flags move on rotate, sleep and status writes; both returns leave them alone
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			flags_q <= FLAGS_RESET;
		else if (cmd_go && instr.op == OP_ROT_RIGHT)
			flags_q.carry <= fval[0];
		else if (cmd_go && instr.op == OP_SLEEP)
		begin
			flags_q.timeout_flag    <= 1'b1;
			flags_q.power_down_flag <= 1'b0;
		end
		else if (wr_fire && aw_addr_q == OFF_STATUS)
		begin
			flags_q.carry           <= wr_word[ST_CARRY_BIT];
			flags_q.timeout_flag    <= wr_word[ST_TO_BIT];
			flags_q.power_down_flag <= wr_word[ST_PD_BIT];
		end
	end

	// PC: returns take it in the second cycle from the entry popped in the first
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pc_q     <= '0;
			ret_pc_q <= '0;
		end
		else if (cmd_go)
		begin
			ret_pc_q <= top_entry;
			if (instr.op == OP_ROT_RIGHT || instr.op == OP_SLEEP)
				pc_q <= pc_q + PC_W'(1);
		end
		else if (state_q == ST_RET2)
			pc_q <= ret_pc_q;
		else if (wr_fire && aw_addr_q == OFF_PC)
			pc_q <= wr_word[PC_W-1:0];
	end

	// Circular return stack, as on the real core: overflow overwrites silently
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			sp_q <= '0;
		else if (cmd_go && (instr.op == OP_RET_LIT || instr.op == OP_RET_SUB))
			sp_q <= sp_q - SP_W'(1);
		else if (wr_fire && aw_addr_q == OFF_STACK)
		begin
			stack_q[sp_q] <= wr_word[PC_W-1:0];
			sp_q          <= sp_q + SP_W'(1);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			fptr_q <= '0;
		else if (wr_fire && aw_addr_q == OFF_FPTR)
			fptr_q <= wr_word[FA_W-1:0];
	end

	// File contents are data, not control, so they carry no reset
	always_ff @(posedge ref_clk)
	begin
		if (cmd_go && instr.op == OP_ROT_RIGHT && instr.dest)
			file_q[instr.faddr] <= rot_res;
		else if (wr_fire && aw_addr_q == OFF_FDATA)
			file_q[fptr_q] <= wr_word[DATA_W-1:0];
	end

	// Watchdog runs off the main clock here, so it holds while asleep
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || (cmd_go && instr.op == OP_SLEEP))
		begin
			wdt_q   <= '0;
			presc_q <= '0;
		end
		else if (!sleep_active)
		begin
			presc_q <= presc_q + PRESC_W'(1);
			if (&presc_q)
				wdt_q <= wdt_q + WDT_W'(1);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_ret_lit_w;
		cmd_go && instr.op == OP_RET_LIT |=> w_q == $past(instr.lit) ##1 pc_q == $past(top_entry, 2);
	endproperty
	a_ret_lit_w: assert property (p_ret_lit_w) else $error("literal return wrong W or PC");

	property p_ret_lit_flags;
		cmd_go && instr.op == OP_RET_LIT |=> $stable(flags_q) [*2];
	endproperty
	a_ret_lit_flags: assert property (p_ret_lit_flags) else $error("literal return changed flags");

	property p_rot_w;
		cmd_go && instr.op == OP_ROT_RIGHT && !instr.dest |=>
			w_q == {$past(flags_q.carry), $past(fval[DATA_W-1:1])} && flags_q.carry == $past(fval[0]);
	endproperty
	a_rot_w: assert property (p_rot_w) else $error("rotate right result wrong");

	property p_rot_dest;
		cmd_go && instr.op == OP_ROT_RIGHT && instr.dest |=> $stable(w_q) && $stable(flags_q.timeout_flag);
	endproperty
	a_rot_dest: assert property (p_rot_dest) else $error("rotate to file touched W");

	property p_ret_sub;
		cmd_go && instr.op == OP_RET_SUB |=> sp_q == $past(sp_q) - SP_W'(1) && busy ##1
			!busy && pc_q == $past(top_entry, 2) && $stable(flags_q);
	endproperty
	a_ret_sub: assert property (p_ret_sub) else $error("subroutine return wrong");

	property p_sleep_flags;
		cmd_go && instr.op == OP_SLEEP |=> flags_q.timeout_flag && !flags_q.power_down_flag &&
			flags_q.carry == $past(flags_q.carry);
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

	property p_sleep_wdt;
		cmd_go && instr.op == OP_SLEEP |=> wdt_q == '0 && presc_q == '0;
	endproperty
	a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared by sleep");

	// Entry edge still steps the PC, and software may reload it while asleep
	property p_sleep_halt;
		sleep_active |-> !osc_run && !cmd_go &&
			($stable(pc_q) || !$past(sleep_active) || $past(wr_fire && aw_addr_q == OFF_PC));
	endproperty
	a_sleep_halt: assert property (p_sleep_halt) else $error("core active in sleep");

	property p_single_cycle;
		cmd_go && (instr.op == OP_ROT_RIGHT || instr.op == OP_SLEEP) |=> !busy && pc_q == $past(pc_q) + PC_W'(1);
	endproperty
	a_single_cycle: assert property (p_single_cycle) else $error("one-cycle op stalled");
endmodule

/* File: rrs_exec_bench.sv */
// Self-checking bench for the four-instruction executor, driven over its AXI4-Lite slave.
// Assumes rrs_pkg is compiled first and the design keeps its default parameters.
`timescale 1ns/1ps
module rrs_exec_bench;
	import rrs_pkg::*;

	logic                   ref_clk;
	logic                   rst_n;
	logic [ADDR_W-1:0]      s_axi_awaddr;
	logic                   s_axi_awvalid;
	logic                   s_axi_awready;
	logic [31:0]            s_axi_wdata;
	logic [3:0]             s_axi_wstrb;
	logic                   s_axi_wvalid;
	logic                   s_axi_wready;
	logic [1:0]             s_axi_bresp;
	logic                   s_axi_bvalid;
	logic                   s_axi_bready;
	logic [ADDR_W-1:0]      s_axi_araddr;
	logic                   s_axi_arvalid;
	logic                   s_axi_arready;
	logic [31:0]            s_axi_rdata;
	logic [1:0]             s_axi_rresp;
	logic                   s_axi_rvalid;
	logic                   s_axi_rready;
	logic                   osc_run;
	logic                   sleep_active;
	int                     n_fail;
	int                     n_compared;

	rrs_exec dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_run(osc_run),
		.sleep_active(sleep_active));

	always #4 ref_clk = ~ref_clk;

	task automatic finish_test();
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	// Ready and valid are sampled right after the edge, before the design's updates land
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic rchk(input logic [5:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, e, d);
		chk("rresp", 32'(RESP_OKAY), 32'(r));
	endtask

	function automatic logic [31:0] cmd(logic [1:0] op, logic [7:0] lit, logic [6:0] fa, logic dest);
		return (32'(op) << CMD_OP_LSB) | (32'(lit) << CMD_LIT_LSB) | (32'(fa) << CMD_FA_LSB)
			| (32'(dest) << CMD_DEST_BIT);
	endfunction

	// Busy always expected low: every read lands after a command has finished
	function automatic logic [31:0] st(logic sl, logic c, logic t, logic p, logic o);
		logic [31:0] v;
		v = '0;
		v[ST_SLEEP_BIT] = sl;
		v[ST_CARRY_BIT] = c;
		v[ST_TO_BIT] = t;
		v[ST_PD_BIT] = p;
		v[ST_OSC_BIT] = o;
		return v;
	endfunction

	task automatic t_reset();
		chk("osc_run", 32'h1, 32'(osc_run));
		chk("sleep_active", 32'h0, 32'(sleep_active));
		rchk(OFF_STATUS, st(0, 1, 1, 0, 1), "status");
		rchk(OFF_WREG, 32'h00, "wreg");
		rchk(OFF_PC, 32'h0, "pc");
	endtask

	task automatic t_ret_lit();
		wr(OFF_STATUS, st(0, 1, 0, 1, 0));
		wr(OFF_STACK, 32'h123);
		wr(OFF_CMD, cmd(OP_RET_LIT, 8'hff, 7'h00, 1'b0));
		rchk(OFF_WREG, 32'hff, "wreg");
		rchk(OFF_PC, 32'h123, "pc");
		rchk(OFF_STATUS, st(0, 1, 0, 1, 1), "status");
	endtask

	task automatic t_ret_sub();
		wr(OFF_STATUS, st(0, 0, 1, 0, 0));
		wr(OFF_WREG, 32'h3c);
		wr(OFF_STACK, 32'h0aa);
		wr(OFF_STACK, 32'h155);
		wr(OFF_CMD, cmd(OP_RET_SUB, 8'h00, 7'h00, 1'b0));
		rchk(OFF_PC, 32'h155, "pc");
		wr(OFF_CMD, cmd(OP_RET_SUB, 8'h00, 7'h00, 1'b0));
		rchk(OFF_PC, 32'h0aa, "pc");
		rchk(OFF_WREG, 32'h3c, "wreg");
		rchk(OFF_STATUS, st(0, 0, 1, 0, 1), "status");
	endtask

	task automatic t_rotate();
		wr(OFF_PC, 32'h010);
		wr(OFF_STATUS, st(0, 1, 1, 1, 0));
		wr(OFF_FPTR, 32'h05);
		wr(OFF_FDATA, 32'h81);
		wr(OFF_CMD, cmd(OP_ROT_RIGHT, 8'h00, 7'h05, 1'b0));
		rchk(OFF_WREG, 32'hc0, "wreg");
		rchk(OFF_FDATA, 32'h81, "fdata");
		rchk(OFF_PC, 32'h011, "pc");
		wr(OFF_STATUS, st(0, 0, 0, 1, 0));
		wr(OFF_FPTR, 32'h7f);
		wr(OFF_FDATA, 32'h7f);
		wr(OFF_CMD, cmd(OP_ROT_RIGHT, 8'h00, 7'h7f, 1'b1));
		rchk(OFF_FDATA, 32'h3f, "fdata");
		rchk(OFF_WREG, 32'hc0, "wreg");
		rchk(OFF_STATUS, st(0, 1, 0, 1, 1), "status");
		rchk(OFF_PC, 32'h012, "pc");
	endtask

	task automatic t_sleep();
		logic [31:0] d0;
		logic [31:0] d1;
		logic [1:0]  r;
		wr(OFF_STATUS, st(0, 1, 0, 1, 0));
		wr(OFF_PC, 32'h020);
		wr(OFF_WREG, 32'h11);
		// Catch a watchdog step, then run on until the prescaler is near its next wrap
		rd(OFF_WDOG, d0, r);
		do rd(OFF_WDOG, d1, r); while (d1 == d0);
		repeat (200) @(posedge ref_clk);
		wr(OFF_CMD, cmd(OP_SLEEP, 8'h00, 7'h00, 1'b0));
		chk("osc_run", 32'h0, 32'(osc_run));
		chk("sleep_active", 32'h1, 32'(sleep_active));
		rchk(OFF_STATUS, st(1, 1, 1, 0, 0), "status");
		rchk(OFF_WDOG, 32'h0, "wdog");
		rchk(OFF_PC, 32'h021, "pc");
		wr(OFF_CMD, cmd(OP_RET_LIT, 8'h99, 7'h00, 1'b0));
		rchk(OFF_WREG, 32'h11, "wreg");
		rchk(OFF_PC, 32'h021, "pc");
		wr(OFF_WAKE, 32'h1);
		chk("osc_run", 32'h1, 32'(osc_run));
		// Well short of one prescaler wrap, so a stale prescaler would show
		repeat (100) @(posedge ref_clk);
		rchk(OFF_WDOG, 32'h0, "wdog");
	endtask

	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0]  r;
		wr(6'h24, 32'hffffffff, RESP_SLVERR);
		rd(6'h3c, d, r);
		chk("rresp", 32'(RESP_SLVERR), 32'(r));
		chk("rdata", 32'h0, d);
	endtask

	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = '0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		n_fail = 0;
		n_compared = 0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_ret_lit();
		t_ret_sub();
		t_rotate();
		t_unmapped();
		t_sleep();
		finish_test();
	end

	// Whole sequence needs roughly 600 cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		finish_test();
	end
endmodule
